/* File: i2cci_pkg.sv */
// Package for the two-wire client interface: states, widths and timing counts.
// Assumes a 100 MHz system clock on both ends.
package i2cci_pkg;
	localparam int unsigned I2CCI_CLK_MHZ = 100;
	// Bit period of the host's own link clock, in ns
	localparam int unsigned I2CCI_SCL_PERIOD_NS = 2500;
	// Half period in system cycles, rounded down
	localparam int unsigned I2CCI_HALF_CYC = (I2CCI_SCL_PERIOD_NS / 2) * I2CCI_CLK_MHZ / 1000;
	localparam logic [6:0] I2CCI_ADDR_RST = 7'h60;
	localparam logic [7:0] I2CCI_BYTE_RST = 8'h00;
	localparam logic [3:0] I2CCI_LAST_BIT = 4'h8;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;

	// Client byte-engine states
	typedef enum logic [2:0] {
		CS_IDLE = 3'b000,
		CS_RX = 3'b001,
		CS_ACK = 3'b010,
		CS_TX = 3'b011,
		CS_MACK = 3'b100,
		CS_IGNORE = 3'b101
	} i2cci_cst_t;

	// Host sequencer states
	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_START = 3'b001,
		HS_BIT = 3'b010,
		HS_STOP = 3'b011,
		HS_DONE = 3'b100
	} i2cci_hst_t;

	// True when a bit counter is on the acknowledge slot
	function automatic logic i2cci_is_ack(input logic [3:0] cnt);
		return cnt == I2CCI_LAST_BIT;
	endfunction
endpackage

/* File: i2cci_if.sv */
// Two-wire bus carrier: open-drain scl and sda resolved from the enables.
// Assumes external pull-ups; a driven enable pulls the line low.
interface i2cci_if;
	logic scl_oe_host;
	logic sda_oe_host;
	logic sda_oe_dev;
	logic scl;
	logic sda;

	// Wired-AND of the open-drain drivers
	assign scl = ~scl_oe_host;
	assign sda = ~(sda_oe_host | sda_oe_dev);

	modport host (output scl_oe_host, output sda_oe_host, input scl, input sda);
	modport dev (output sda_oe_dev, input scl, input sda);
endinterface

/* File: i2cci_sync.sv */
// Two-flop synchroniser for the bus lines plus edge and condition detection.
// Assumes asynchronous inputs; outputs are in the i_clk domain.
module i2cci_sync
	import i2cci_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda,
	output logic o_scl_rise,
	output logic o_scl_fall,
	output logic o_start,
	output logic o_stop
);
	logic [1:0] scl_meta_ff, sda_meta_ff;
	logic [1:0] nxt_scl_meta, nxt_sda_meta;
	logic scl_d_ff, sda_d_ff;

	// Shift the lines in; only the second stage is looked at
	always_comb begin
		nxt_scl_meta = {scl_meta_ff[0], i_scl};
		nxt_sda_meta = {sda_meta_ff[0], i_sda};
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_meta_ff <= 2'h3;
			sda_meta_ff <= 2'h3;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_meta_ff <= nxt_scl_meta;
			sda_meta_ff <= nxt_sda_meta;
			scl_d_ff <= scl_meta_ff[1];
			sda_d_ff <= sda_meta_ff[1];
		end
	end

	// Conditions only count while scl stays high across the sda edge
	assign o_scl = scl_meta_ff[1];
	assign o_sda = sda_meta_ff[1];
	assign o_scl_rise = scl_meta_ff[1] & ~scl_d_ff;
	assign o_scl_fall = ~scl_meta_ff[1] & scl_d_ff;
	assign o_start = scl_meta_ff[1] & scl_d_ff & sda_d_ff & ~sda_meta_ff[1];
	assign o_stop = scl_meta_ff[1] & scl_d_ff & ~sda_d_ff & sda_meta_ff[1];
endmodule

/* File: i2cci_dev.sv */
// Client end of the two-wire bus: address match, register writes and reads.
// Assumes a user-side register store that answers reads in the same cycle.
//
// Contract
// - Data changes only while clock is low
// - Start is sda fall with scl high
// - Stop is sda rise with scl high
// - Bus busy from start until stop
// - Repeated start behaves as plain start
// - Host starts transfers; client never initiates
// - Whole bytes, unlimited count per transfer
// - Bytes travel most significant bit first
// - Host makes every clock, ninth included
// - No clock stretching; work done within ack
// - Receiver pulls sda low for ack
// - Nack is sda high whole ninth pulse
// - Nack an address that does not match
// - Nack while busy with real-time work; here only the address byte is nacked on i_rt_busy
// - Nack unrecognised bytes or when full; here only data bytes are nacked, and only on i_wr_full
// - Host nacks last read byte
// - After nack host stops or restarts
// - Works at standard, fast, fast-plus rates
// - Write: address, register, data, stop
// - Further write bytes go to address plus one
// - Read: register, restart, address read, data
module i2cci_dev
	import i2cci_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	i2cci_if.dev bus,
	input wire logic [6:0] i_own_addr,
	input wire logic i_rt_busy,
	input wire logic i_wr_full,
	input wire logic [7:0] i_rd_data,
	output logic o_busy,
	output logic o_wr_stb,
	output logic [7:0] o_reg_addr,
	output logic [7:0] o_wr_data,
	output logic o_rd_stb
);
	logic sda_s, scl_rise, scl_fall, start_c, stop_c;
	i2cci_cst_t st_ff, nxt_st;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] sh_ff, nxt_sh;
	logic [1:0] idx_ff, nxt_idx; // 0 address byte, 1 register byte, 2 data
	logic rw_ff, nxt_rw;
	logic ack_ff, nxt_ack;
	logic sda_oe_ff, nxt_sda_oe;
	logic busy_ff, nxt_busy;
	logic wr_stb_ff, nxt_wr_stb;
	logic rd_stb_ff, nxt_rd_stb;
	logic [7:0] ra_ff, nxt_ra;
	logic [7:0] wd_ff, nxt_wd;
	logic [7:0] rx_byte;

	// Lines are synchronised before any edge or condition logic
	// Oversampling at the system clock follows every rate up to fast-plus
	i2cci_sync u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_scl(bus.scl),
		.i_sda(bus.sda),
		.o_scl(),
		.o_sda(sda_s),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall),
		.o_start(start_c),
		.o_stop(stop_c)
	);

	assign rx_byte = sh_ff;

	// Byte engine: samples on scl rise, drives on scl fall
	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_idx = idx_ff;
		nxt_rw = rw_ff;
		nxt_ack = ack_ff;
		nxt_sda_oe = sda_oe_ff;
		nxt_busy = busy_ff;
		nxt_wr_stb = 1'b0;
		nxt_rd_stb = 1'b0;
		nxt_ra = ra_ff;
		nxt_wd = wd_ff;
		if (start_c) begin
			// Any start, repeated or not, restarts address reception
			nxt_busy = 1'b1;
			nxt_st = CS_RX;
			nxt_cnt = 4'h0;
			nxt_idx = 2'h0;
			nxt_sda_oe = 1'b0;
		end else if (stop_c) begin
			nxt_busy = 1'b0;
			nxt_st = CS_IDLE;
			nxt_sda_oe = 1'b0;
		end else begin
			unique case (st_ff)
				CS_IDLE, CS_IGNORE: begin
					nxt_sda_oe = 1'b0;
				end
				CS_RX: begin
					if (scl_rise) begin
						// Sample while scl is high, msb first
						nxt_sh = {sh_ff[6:0], sda_s};
						nxt_cnt = cnt_ff + 4'h1;
					end else if (scl_fall && i2cci_is_ack(cnt_ff)) begin
						// Decide ack before the ninth pulse; no stretching
						nxt_ack = 1'b1;
						if (idx_ff == 2'h0) begin
							nxt_rw = rx_byte[0];
							// Foreign address or busy leaves sda released
							nxt_ack = (rx_byte[7:1] == i_own_addr) && !i_rt_busy;
							if (rx_byte[0] == RW_READ)
								nxt_rd_stb = nxt_ack;
						end else if (idx_ff == 2'h1) begin
							nxt_ra = rx_byte;
						end else begin
							nxt_ack = !i_wr_full;
							if (!i_wr_full) begin
								nxt_wd = rx_byte;
								nxt_wr_stb = 1'b1;
							end
						end
						nxt_sda_oe = nxt_ack;
						nxt_st = CS_ACK;
					end
				end
				CS_ACK: begin
					// Release after the ninth pulse, or drive the first read bit
					if (scl_fall) begin
						nxt_sda_oe = 1'b0;
						nxt_cnt = 4'h0;
						if (!ack_ff) begin
							nxt_st = CS_IGNORE;
						end else if (idx_ff == 2'h0 && rw_ff == RW_READ) begin
							nxt_st = CS_TX;
							nxt_sh = i_rd_data;
							nxt_sda_oe = ~i_rd_data[7];
							nxt_cnt = 4'h1;
						end else begin
							if (idx_ff == 2'h2)
								nxt_ra = ra_ff + 8'h01;
							else
								nxt_idx = idx_ff + 2'h1;
							nxt_st = CS_RX;
						end
					end
				end
				CS_TX: begin
					// Shift out on scl fall so sda is stable while high
					if (scl_fall) begin
						if (i2cci_is_ack(cnt_ff)) begin
							nxt_sda_oe = 1'b0; // Release for the host's ack
							nxt_st = CS_MACK;
						end else begin
							nxt_sh = {sh_ff[6:0], 1'b0};
							nxt_sda_oe = ~sh_ff[6];
							nxt_cnt = cnt_ff + 4'h1;
						end
					end
				end
				CS_MACK: begin
					if (scl_rise) begin
						// Host nack ends the read; ack fetches the next register
						if (sda_s) begin
							nxt_st = CS_IGNORE;
						end else begin
							nxt_ra = ra_ff + 8'h01;
							nxt_rd_stb = 1'b1;
						end
					end else if (scl_fall) begin
						nxt_st = CS_TX;
						nxt_sh = i_rd_data;
						nxt_sda_oe = ~i_rd_data[7];
						nxt_cnt = 4'h1;
					end
				end
				default: nxt_st = CS_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= CS_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= I2CCI_BYTE_RST;
			idx_ff <= 2'h0;
			rw_ff <= RW_WRITE;
			ack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			busy_ff <= 1'b0;
			wr_stb_ff <= 1'b0;
			rd_stb_ff <= 1'b0;
			ra_ff <= I2CCI_BYTE_RST;
			wd_ff <= I2CCI_BYTE_RST;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			idx_ff <= nxt_idx;
			rw_ff <= nxt_rw;
			ack_ff <= nxt_ack;
			sda_oe_ff <= nxt_sda_oe;
			busy_ff <= nxt_busy;
			wr_stb_ff <= nxt_wr_stb;
			rd_stb_ff <= nxt_rd_stb;
			ra_ff <= nxt_ra;
			wd_ff <= nxt_wd;
		end
	end

	// Open-drain only: the enable pulls low, nothing drives high
	assign bus.sda_oe_dev = sda_oe_ff;
	assign o_busy = busy_ff;
	assign o_wr_stb = wr_stb_ff;
	assign o_reg_addr = ra_ff;
	assign o_wr_data = wd_ff;
	assign o_rd_stb = rd_stb_ff;
endmodule

/* File: i2cci_host.sv */
// Host end: makes scl by division and runs one byte or condition per command.
// Assumes the user issues a new command only while o_ready is high.
module i2cci_host
	import i2cci_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	i2cci_if.host bus,
	input wire logic i_cmd_vld,
	input wire logic [1:0] i_cmd, // 0 start, 1 write byte, 2 read byte, 3 stop
	input wire logic [7:0] i_wdata,
	input wire logic i_rd_nack,
	output logic o_ready,
	output logic [7:0] o_rdata,
	output logic o_acked,
	output logic o_done
);
	i2cci_hst_t st_ff, nxt_st;
	logic [15:0] div_ff, nxt_div;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [8:0] sh_ff, nxt_sh;
	logic rd_ff, nxt_rd;
	logic scl_oe_ff, nxt_scl_oe;
	logic sda_oe_ff, nxt_sda_oe;
	logic [1:0] ph_ff, nxt_ph;
	logic acked_ff, nxt_acked;
	logic [7:0] rdata_ff, nxt_rdata;
	logic done_ff, nxt_done;
	logic ready_ff, nxt_ready;
	logic [1:0] sda_meta_ff;
	logic tick;

	assign tick = (div_ff == 16'(I2CCI_HALF_CYC - 1));

	// Each half period is one phase; data moves with scl low
	always_comb begin
		nxt_st = st_ff;
		nxt_div = tick ? 16'h0000 : div_ff + 16'h0001;
		nxt_cnt = cnt_ff;
		nxt_sh = sh_ff;
		nxt_rd = rd_ff;
		nxt_scl_oe = scl_oe_ff;
		nxt_sda_oe = sda_oe_ff;
		nxt_ph = ph_ff;
		nxt_acked = acked_ff;
		nxt_rdata = rdata_ff;
		nxt_done = 1'b0;
		unique case (st_ff)
			HS_IDLE: begin
				nxt_div = 16'h0000;
				// Commands that arrive while not ready are dropped
				if (i_cmd_vld && ready_ff) begin
					nxt_ph = 2'h0;
					nxt_rd = (i_cmd == 2'h2);
					if (i_cmd == 2'h0) begin
						nxt_st = HS_START;
					end else if (i_cmd == 2'h3) begin
						nxt_st = HS_STOP;
					end else begin
						// Ninth bit: release for ack, or our own ack/nack when reading
						nxt_sh = (i_cmd == 2'h2) ? {8'hff, i_rd_nack} : {i_wdata, 1'b1};
						nxt_cnt = 4'h0;
						nxt_st = HS_BIT;
					end
				end
			end
			HS_START: begin
				// Release both, then sda low under high scl, then scl low
				if (tick) begin
					nxt_ph = ph_ff + 2'h1;
					unique case (ph_ff)
						2'h0: nxt_sda_oe = 1'b0;
						2'h1: nxt_scl_oe = 1'b0;
						2'h2: nxt_sda_oe = 1'b1;
						2'h3: begin
							nxt_scl_oe = 1'b1;
							nxt_st = HS_DONE;
						end
					endcase
				end
			end
			HS_BIT: begin
				// Move sda halfway through the low phase, clear of both scl edges
				if (!ph_ff[0] && div_ff == 16'(I2CCI_HALF_CYC / 2))
					nxt_sda_oe = ~sh_ff[8];
				if (tick) begin
					nxt_ph = {1'b0, ~ph_ff[0]};
					if (ph_ff[0] == 1'b0) begin
						// Raise scl once sda has settled
						nxt_scl_oe = 1'b0;
					end else begin
						nxt_sh = {sh_ff[7:0], sda_meta_ff[1]};
						nxt_scl_oe = 1'b1;
						nxt_cnt = cnt_ff + 4'h1;
						if (i2cci_is_ack(cnt_ff)) begin
							// Sda stays put as scl falls; the next phase moves it
							nxt_acked = ~sda_meta_ff[1];
							if (rd_ff)
								nxt_rdata = sh_ff[7:0];
							nxt_st = HS_DONE;
						end
					end
				end
			end
			HS_STOP: begin
				// Sda low under low scl, raise scl, then release sda
				if (tick) begin
					nxt_ph = ph_ff + 2'h1;
					unique case (ph_ff)
						2'h0: nxt_sda_oe = 1'b1;
						2'h1: nxt_scl_oe = 1'b0;
						2'h2: nxt_sda_oe = 1'b0;
						2'h3: nxt_st = HS_DONE;
					endcase
				end
			end
			HS_DONE: begin
				nxt_done = 1'b1;
				nxt_st = HS_IDLE;
			end
			default: nxt_st = HS_IDLE;
		endcase
		// Registered so the ready output comes straight from a flop
		nxt_ready = (nxt_st == HS_IDLE) && !nxt_done;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_ff <= HS_IDLE;
			div_ff <= 16'h0000;
			cnt_ff <= 4'h0;
			sh_ff <= 9'h000;
			rd_ff <= 1'b0;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			ph_ff <= 2'h0;
			acked_ff <= 1'b0;
			rdata_ff <= I2CCI_BYTE_RST;
			done_ff <= 1'b0;
			ready_ff <= 1'b1;
			sda_meta_ff <= 2'h3;
		end else begin
			st_ff <= nxt_st;
			div_ff <= nxt_div;
			cnt_ff <= nxt_cnt;
			sh_ff <= nxt_sh;
			rd_ff <= nxt_rd;
			scl_oe_ff <= nxt_scl_oe;
			sda_oe_ff <= nxt_sda_oe;
			ph_ff <= nxt_ph;
			acked_ff <= nxt_acked;
			rdata_ff <= nxt_rdata;
			done_ff <= nxt_done;
			ready_ff <= nxt_ready;
			sda_meta_ff <= {sda_meta_ff[0], bus.sda};
		end
	end

	assign bus.scl_oe_host = scl_oe_ff;
	assign bus.sda_oe_host = sda_oe_ff;
	assign o_ready = ready_ff;
	assign o_rdata = rdata_ff;
	assign o_acked = acked_ff;
	assign o_done = done_ff;
endmodule

/* File: i2cci_props.sv */
// Checker for the two-wire bus between the host and client ends.
// Assumes it watches the resolved lines and enables of one bus carrier.
module i2cci_props (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic scl_oe_host,
	input wire logic sda_oe_host,
	input wire logic sda_oe_dev,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// Conditions as seen on the raw lines, scl high on both samples
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence

	// Client data may only move while the clock is low
	a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_oe_dev))
		else $error("client sda changed while scl high");
	a_dev_only_low: assert property (sda_oe_dev |-> !sda)
		else $error("client drive did not pull sda low");
	a_quiet_after_start: assert property (s_start |-> !sda_oe_dev [*8])
		else $error("client drove sda right after start");
	a_quiet_after_stop: assert property (s_stop |-> !sda_oe_dev [*8])
		else $error("client drove sda right after stop");
	a_idle_after_stop: assert property (s_stop |=> (scl && sda) [*4])
		else $error("bus not idle after stop");
	a_ack_whole_high: assert property ($rose(scl) && sda_oe_dev |-> sda_oe_dev [*8])
		else $error("client ack dropped during high phase");
	a_scl_high_min: assert property ($fell(scl) |-> $past(scl, 8))
		else $error("scl high phase too short");
	a_scl_low_min: assert property ($fell(scl) |=> (!scl) [*8])
		else $error("scl low phase too short");
	a_host_lets_go: assert property ($rose(scl) && sda_oe_dev |-> !sda_oe_host)
		else $error("host drove sda while client was sending");

	c_start: cover property (s_start);
	c_stop: cover property (s_stop);
	c_dev_ack: cover property ($rose(scl) && sda_oe_dev);
	c_host_release: cover property ($fell(scl_oe_host) && !sda_oe_host);
endmodule

/* File: i2c_client_interface_test.sv */
// Testbench joining host and client ends on one bus carrier.
// Assumes a 100 MHz clock; the host makes scl by division.
module i2c_client_interface_test;
	timeunit 1ns;
	timeprecision 1ps;
	import i2cci_pkg::*;
	logic i_clk, i_rst_n, cmd_vld, rd_nack, rt_busy, wr_full, o_ready, o_acked, o_done;
	logic o_busy, o_wr_stb, o_rd_stb;
	logic [1:0] cmd;
	logic [7:0] wdata, o_rdata, o_reg_addr, o_wr_data, rd_data, wa, wd;
	logic [8:0] sh;
	int mismatches, samples_checked, nwr, nrd;

	i2cci_if i2cci_if_i ();
	i2cci_host i2cci_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(i2cci_if_i),
		.i_cmd_vld(cmd_vld), .i_cmd(cmd), .i_wdata(wdata), .i_rd_nack(rd_nack),
		.o_ready(o_ready), .o_rdata(o_rdata), .o_acked(o_acked), .o_done(o_done));
	i2cci_dev i2cci_dev_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(i2cci_if_i),
		.i_own_addr(I2CCI_ADDR_RST), .i_rt_busy(rt_busy), .i_wr_full(wr_full), .i_rd_data(rd_data),
		.o_busy(o_busy), .o_wr_stb(o_wr_stb), .o_reg_addr(o_reg_addr),
		.o_wr_data(o_wr_data), .o_rd_stb(o_rd_stb));
	i2cci_props i2cci_props_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.scl_oe_host(i2cci_if_i.scl_oe_host), .sda_oe_host(i2cci_if_i.sda_oe_host),
		.sda_oe_dev(i2cci_if_i.sda_oe_dev), .scl(i2cci_if_i.scl), .sda(i2cci_if_i.sda));

	// Register store: a fixed offset so each address reads back differently
	assign rd_data = o_reg_addr + 8'h33;

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Last nine bits seen on the wire, data then ack, sampled on scl rise
	always @(posedge i2cci_if_i.scl) begin
		sh <= {sh[7:0], i2cci_if_i.sda};
	end

	// Capture every register write the client hands out, and count read fetches
	always @(posedge i_clk) begin
		if (o_wr_stb === 1'b1) begin
			wa <= o_reg_addr;
			wd <= o_wr_data;
			nwr <= nwr + 1;
		end
		if (o_rd_stb === 1'b1)
			nrd <= nrd + 1;
	end

	task automatic wrap_up();
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e) begin
			$display("unexpected %s: expected %h seen %h", nm, e, s);
			mismatches++;
		end
	endtask

	// One host command; waits for ready before and done after, both bounded
	task automatic op(input logic [1:0] c, input logic [7:0] d, input logic nk);
		int n;
		n = 0;
		while (o_ready !== 1'b1 && n < 5000) begin
			@(posedge i_clk);
			#1 n++;
		end
		cmd_vld = 1'b1;
		cmd = c;
		wdata = d;
		rd_nack = nk;
		@(posedge i_clk);
		#1 cmd_vld = 1'b0;
		while (o_done !== 1'b1 && n < 5000) begin
			@(posedge i_clk);
			#1 n++;
		end
		if (n >= 5000) begin
			$display("unexpected done: expected 1 seen 0");
			mismatches++;
		end
	endtask

	// Host writes a byte; checks wire bit order and the ack slot
	task automatic wrb(input logic [7:0] d, input logic ack);
		op(2'h1, d, 1'b0);
		chk("acked", {7'h00, ack}, {7'h00, o_acked});
		chk("wire byte", d, sh[8:1]);
		chk("wire ack", {7'h00, ~ack}, {7'h00, sh[0]});
	endtask

	// Host reads a byte, acking or not
	task automatic rdb(input logic [7:0] e, input logic nk);
		op(2'h2, 8'h00, nk);
		chk("rdata", e, o_rdata);
		chk("wire byte", e, sh[8:1]);
		chk("wire host ack", {7'h00, nk}, {7'h00, sh[0]});
	endtask

	// Hang guard: the whole run needs about 40,000 cycles
	initial begin
		repeat (60000) @(posedge i_clk);
		mismatches++;
		wrap_up();
	end

	// Main sequence
	initial begin
		i_rst_n = 1'b0;
		cmd_vld = 1'b0;
		cmd = 2'h0;
		wdata = 8'h00;
		rd_nack = 1'b0;
		rt_busy = 1'b0;
		wr_full = 1'b0;
		sh = 9'h000;
		nwr = 0;
		nrd = 0;
		mismatches = 0;
		samples_checked = 0;
		repeat (20) @(posedge i_clk);
		#1 i_rst_n = 1'b1;
		// Two-byte write, second byte lands at the next address
		op(2'h0, 8'h00, 1'b0);
		chk("busy", 8'h01, {7'h00, o_busy});
		wrb(8'hc0, 1'b1);
		wrb(8'h10, 1'b1);
		wrb(8'ha5, 1'b1);
		chk("write addr", 8'h10, wa);
		chk("write data", 8'ha5, wd);
		wrb(8'h3c, 1'b1);
		chk("write addr", 8'h11, wa);
		chk("write data", 8'h3c, wd);
		op(2'h3, 8'h00, 1'b0);
		chk("busy", 8'h00, {7'h00, o_busy});
		chk("write count", 8'h02, 8'(nwr));
		// Register read through a repeated start, two bytes
		op(2'h0, 8'h00, 1'b0);
		wrb(8'hc0, 1'b1);
		wrb(8'h20, 1'b1);
		op(2'h0, 8'h00, 1'b0);
		wrb(8'hc1, 1'b1);
		rdb(8'h53, 1'b0);
		rdb(8'h54, 1'b1);
		chk("read fetches", 8'h02, 8'(nrd));
		op(2'h3, 8'h00, 1'b0);
		// Foreign address is refused, a restart then succeeds
		op(2'h0, 8'h00, 1'b0);
		wrb(8'hc2, 1'b0);
		op(2'h0, 8'h00, 1'b0);
		wrb(8'hc0, 1'b1);
		op(2'h3, 8'h00, 1'b0);
		// Busy with real-time work: address refused
		rt_busy = 1'b1;
		op(2'h0, 8'h00, 1'b0);
		wrb(8'hc0, 1'b0);
		op(2'h3, 8'h00, 1'b0);
		rt_busy = 1'b0;
		// Store full: data byte refused and not written
		op(2'h0, 8'h00, 1'b0);
		wrb(8'hc0, 1'b1);
		wrb(8'h30, 1'b1);
		wr_full = 1'b1;
		wrb(8'h77, 1'b0);
		chk("write count", 8'h02, 8'(nwr));
		wr_full = 1'b0;
		op(2'h3, 8'h00, 1'b0);
		chk("busy", 8'h00, {7'h00, o_busy});
		wrap_up();
	end
endmodule
